// ### cmsel_pkg.sv
package cmsel_pkg;

    // Strap code width and the eight clock generation codes.
    localparam int unsigned STRAP_W = 3;
    localparam logic [2:0] CODE_X4      = 3'h7;
    localparam logic [2:0] CODE_X3      = 3'h6;
    localparam logic [2:0] CODE_X8      = 3'h5;
    localparam logic [2:0] CODE_X5      = 3'h4;
    localparam logic [2:0] CODE_DIRECT  = 3'h3;
    localparam logic [2:0] CODE_X10     = 3'h2;
    localparam logic [2:0] CODE_PRESCL  = 3'h1;
    localparam logic [2:0] CODE_X16     = 3'h0;

    // Multiplication factors carried to the PLL control.
    localparam int unsigned FACTOR_W = 5;
    localparam logic [4:0] FACTOR_1  = 5'h01;
    localparam logic [4:0] FACTOR_3  = 5'h03;
    localparam logic [4:0] FACTOR_4  = 5'h04;
    localparam logic [4:0] FACTOR_5  = 5'h05;
    localparam logic [4:0] FACTOR_8  = 5'h08;
    localparam logic [4:0] FACTOR_10 = 5'h0A;
    localparam logic [4:0] FACTOR_16 = 5'h10;
    localparam logic [4:0] FACTOR_NONE = 5'h00;

    // System configuration word and the watchdog disable field.
    localparam int unsigned SYSCFG_W    = 16;
    localparam int unsigned OWD_DIS_BIT = 4;
    localparam logic        OWD_DIS_RST = 1'b0;

    // Reset values.
    localparam logic [2:0] MODE_RST   = CODE_X4;
    localparam logic [4:0] FACTOR_RST = FACTOR_4;

    // Cycles after reset release before the strap sample is trusted.
    localparam int unsigned SETTLE_W      = 2;
    localparam logic [1:0]  SETTLE_CYCLES = 2'h3;

    // Source that drives the core clock.
    typedef enum logic [1:0] {
        SRC_PLL,
        SRC_CRYSTAL,
        SRC_PRESCALER
    } cmsel_src_type;

    // Strap capture sequence.
    typedef enum logic {
        CAP_SAMPLE,
        CAP_LOCKED
    } cmsel_cap_type;

endpackage

// ### cmsel_sync3.sv
`timescale 1ns/10ps
`default_nettype none

module cmsel_sync3 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             nrst,
    // Asynchronous input.
    input  wire logic [WIDTH-1:0] async_in,
    // Second and third stage, compared by the user.
    output logic      [WIDTH-1:0] stage2,
    output logic      [WIDTH-1:0] stage3
);

    logic [WIDTH-1:0] stage1_reg;

    // Three flops; only the second reads the first.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            stage2     <= '0;
            stage3     <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2     <= stage1_reg;
            stage3     <= stage2;
        end
    end

endmodule

`default_nettype wire

// ### cmsel_core.sv
// Operation
// [RL1] The clock mechanism is chosen from the three strap pins at reset.
// [RL2] Codes 111,110,101,100,010,000 select PLL factors 4,3,8,5,10,16.
// [RL3] Code 011 is direct drive: oscillator amplifier bypassed, factor one.
// [RL4] Code 001 selects the divide-by-two prescaler, half the input rate.
// [RL5] In prescaler mode each core clock phase lasts one input period.
// [RL6] With watchdog disable clear the PLL free-runs for the watchdog.
// [RL7] With the watchdog disable bit set the PLL is switched off entirely.
// [RL8] Both core clock edges trigger operations, so each is signalled; the code marks them in prescaler and direct drive modes only.
// [RL9] Watchdog disable is bit 4 of the config word, clear after reset.
// [RL10] In direct drive the core clock comes from the crystal pin.
// [RL11] The strap code is latched after reset release and held until reset.
`timescale 1ns/10ps
`default_nettype none

module cmsel_core
    import cmsel_pkg::*;
(
    // Clock and reset; clk stands for the input clock.
    input  wire logic                clk,
    input  wire logic                nrst,
    // Mode strap pins, asynchronous.
    input  wire logic [STRAP_W-1:0]  clock_mode_strap_pins,
    // System configuration word from on-chip logic.
    input  wire logic [SYSCFG_W-1:0] system_config_register,
    // Latched mode.
    output logic      [STRAP_W-1:0]  mode_code,
    output logic                     mode_locked,
    // PLL and oscillator control.
    output logic                     pll_enable,
    output logic                     pll_free_run,
    output logic      [FACTOR_W-1:0] pll_factor,
    output logic                     osc_amp_bypass,
    output logic                     osc_watchdog_disable,
    output cmsel_src_type            core_src_sel,
    // Core clock in prescaler mode and edge markers.
    output logic                     core_clk,
    output logic                     core_edge_rise,
    output logic                     core_edge_fall
);

    // Synchroniser taps for the strap code.
    logic [STRAP_W-1:0]  strap_s2;
    logic [STRAP_W-1:0]  strap_s3;
    // Capture sequence state and its settle counter.
    cmsel_cap_type       cap_state_reg;
    logic [SETTLE_W-1:0] settle_reg;
    // Latched mode and the registered watchdog disable flag.
    logic [STRAP_W-1:0]  mode_reg;
    logic                owd_dis_reg;
    // Decoded clock control, registered further down.
    logic                pll_core_next;
    logic [FACTOR_W-1:0] factor_next;

    // Strap pins come from outside the clock domain.
    // Two agreeing late stages mean the pins held one value for a full
    // cycle, so a code caught mid-change is never taken.
    cmsel_sync3 #(
        .WIDTH (STRAP_W)
    ) u_strap_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (clock_mode_strap_pins),
        .stage2   (strap_s2),
        .stage3   (strap_s3)
    );

    // Wait for the synchroniser to fill, then take a stable code once.
    // Flops reset to constants, so the pins are read only after release.
    // The synchroniser is itself held in reset, so the straps must still
    // stand for a few cycles after release; a pin that moves in that
    // window only delays the lock and never yields a mixed code.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cap_state_reg <= CAP_SAMPLE;
            settle_reg    <= '0;
            mode_reg      <= MODE_RST;
        end else begin
            case (cap_state_reg)
                CAP_SAMPLE: begin
                    // Stages that disagree keep the sequence waiting.
                    if (settle_reg != SETTLE_CYCLES) begin
                        settle_reg <= settle_reg + 2'h1;
                    // [RL1] Sample strap code.
                    end else if (strap_s2 == strap_s3) begin
                        mode_reg      <= strap_s3;
                        cap_state_reg <= CAP_LOCKED;
                    end
                end
                // [RL11] Hold until reset.
                CAP_LOCKED: begin
                    // Later pin activity is ignored without any sign.
                    mode_reg <= mode_reg;
                end
                default: begin
                    // Recover to sampling from an unknown state.
                    cap_state_reg <= CAP_SAMPLE;
                end
            endcase
        end
    end

    // Mode outputs; the default x4 code shows until the lock.
    assign mode_code   = mode_reg;
    assign mode_locked = (cap_state_reg == CAP_LOCKED);

    // Watchdog disable bit taken from the configuration word.
    // The clock controls register this flag again, so a change of the
    // bit reaches the PLL enable two cycles after the word changes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // [RL9] Watchdog enabled after reset.
            owd_dis_reg <= OWD_DIS_RST;
        end else begin
            owd_dis_reg <= system_config_register[OWD_DIS_BIT];
        end
    end

    // The flag is also shown to the watchdog logic outside.
    assign osc_watchdog_disable = owd_dis_reg;

    // Decode of the latched code into factor and source.
    // All eight codes are listed; the default only catches unknown
    // values and falls back to the reset configuration.
    always_comb begin
        pll_core_next = 1'b1;
        factor_next   = FACTOR_NONE;
        case (mode_reg)
            // [RL2] PLL multiplication factors.
            CODE_X4:  factor_next = FACTOR_4;
            CODE_X3:  factor_next = FACTOR_3;
            CODE_X8:  factor_next = FACTOR_8;
            CODE_X5:  factor_next = FACTOR_5;
            CODE_X10: factor_next = FACTOR_10;
            CODE_X16: factor_next = FACTOR_16;
            // [RL3] Direct drive at factor one.
            CODE_DIRECT: begin
                pll_core_next = 1'b0;
                factor_next   = FACTOR_1;
            end
            // [RL4] Prescaler, no PLL factor.
            CODE_PRESCL: begin
                pll_core_next = 1'b0;
                factor_next   = FACTOR_NONE;
            end
            default: begin
                pll_core_next = 1'b1;
                factor_next   = FACTOR_RST;
            end
        endcase
    end

    // Registered clock control; held in the default until the code locks.
    // Until then mode_reg holds the x4 code, so the outputs show the PLL
    // setting of a cold start. These are levels only: switching the
    // clock tree without glitches is left to the clock generator.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pll_enable     <= 1'b1;
            pll_free_run   <= 1'b0;
            pll_factor     <= FACTOR_RST;
            osc_amp_bypass <= 1'b0;
            core_src_sel   <= SRC_PLL;
        end else if (pll_core_next) begin
            // PLL modes: the PLL makes the core clock at the factor.
            pll_enable     <= 1'b1;
            pll_free_run   <= 1'b0;
            pll_factor     <= factor_next;
            osc_amp_bypass <= 1'b0;
            core_src_sel   <= SRC_PLL;
        end else begin
            // Direct drive and prescaler: the PLL serves only the watchdog.
            // [RL6] Free-running PLL feeds the watchdog.
            // [RL7] Disable bit switches the PLL off.
            pll_enable     <= !owd_dis_reg;
            pll_free_run   <= !owd_dis_reg;
            pll_factor     <= factor_next;
            // [RL10] Crystal pin drives the core clock.
            osc_amp_bypass <= (mode_reg == CODE_DIRECT);
            core_src_sel   <= (mode_reg == CODE_DIRECT) ? SRC_CRYSTAL
                                                        : SRC_PRESCALER;
        end
    end

    // Divide-by-two core clock: toggling on every rising input edge makes
    // each phase one input period, independent of input duty cycle.
    // Outside prescaler mode the output is parked low, so a consumer
    // sees no stray edges while another source drives the core.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_clk <= 1'b0;
        end else if (mode_locked && mode_reg == CODE_PRESCL) begin
            // [RL5] One period per phase.
            core_clk <= !core_clk;
        end else begin
            core_clk <= 1'b0;
        end
    end

    // Edge markers for the clock half period. In direct drive both core
    // edges fall in one input period, so both markers pulse together.
    // PLL modes give no markers: the multiplied clock is analog.
    // In prescaler mode a marker is high in the cycle that follows the
    // edge it reports, aligned with core_clk, so a consumer needs no
    // edge detector of its own.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_edge_rise <= 1'b0;
            core_edge_fall <= 1'b0;
        end else if (mode_locked && mode_reg == CODE_PRESCL) begin
            // [RL8] Signal each core edge.
            core_edge_rise <= !core_clk;
            core_edge_fall <= core_clk;
        end else if (mode_locked && mode_reg == CODE_DIRECT) begin
            // Every input period holds both core edges.
            core_edge_rise <= 1'b1;
            core_edge_fall <= 1'b1;
        end else begin
            core_edge_rise <= 1'b0;
            core_edge_fall <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### cmsel_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module cmsel_core_props
    import cmsel_pkg::*;
(
    // Clock, reset and inputs.
    input wire logic                clk,
    input wire logic                nrst,
    input wire logic [STRAP_W-1:0]  clock_mode_strap_pins,
    input wire logic [SYSCFG_W-1:0] system_config_register,
    // Design outputs.
    input wire logic [STRAP_W-1:0]  mode_code,
    input wire logic                mode_locked,
    input wire logic                pll_enable,
    input wire logic                pll_free_run,
    input wire logic [FACTOR_W-1:0] pll_factor,
    input wire logic                osc_amp_bypass,
    input wire logic                osc_watchdog_disable,
    input wire cmsel_src_type       core_src_sel,
    input wire logic                core_clk,
    input wire logic                core_edge_rise,
    input wire logic                core_edge_fall
);
    // Expected factor per code, indexed by the code itself.
    localparam logic [4:0] FT [0:7] = '{5'h10, 5'h00, 5'h0A, 5'h01,
                                        5'h05, 5'h08, 5'h03, 5'h04};
    wire presc = core_src_sel == SRC_PRESCALER;
    wire nopll = mode_code inside {CODE_DIRECT, CODE_PRESCL};
    wire cfg_dis = system_config_register[OWD_DIS_BIT];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_lock_bound: assert property (
        !mode_locked |-> ##[1:8] mode_locked)
        else $error("strap code not latched in time");
    a_mode_hold: assert property (
        mode_locked |=> mode_locked && $stable(mode_code))
        else $error("latched mode changed");
    a_factor_map: assert property (
        $past(mode_locked) |-> pll_factor == FT[mode_code])
        else $error("factor does not match code");
    a_bypass_direct: assert property (
        $past(mode_locked)
        |-> osc_amp_bypass == (mode_code == CODE_DIRECT))
        else $error("bypass wrong for code");
    a_presc_src: assert property (
        $past(mode_locked) && mode_code == CODE_PRESCL |-> presc)
        else $error("prescaler not selected");
    a_presc_toggle: assert property (
        presc && $past(presc, 2) |-> core_clk != $past(core_clk))
        else $error("prescaled clock phase not one cycle");
    a_edge_mark: assert property (
        presc && $past(presc, 2)
        |-> core_edge_rise == core_clk && core_edge_fall == !core_clk)
        else $error("edge markers wrong");
    a_direct_edge: assert property (
        $past(mode_locked) && mode_code == CODE_DIRECT
        |-> core_edge_rise && core_edge_fall)
        else $error("direct drive edge markers missing");
    a_wdog_flag: assert property (
        $past(nrst) |-> osc_watchdog_disable == $past(cfg_dis))
        else $error("watchdog flag not one cycle late");
    a_pll_switch: assert property (
        $past(mode_locked, 2) && nopll
        |-> pll_enable == !$past(cfg_dis, 2) && pll_free_run == pll_enable)
        else $error("pll state wrong for watchdog flag");
endmodule
bind cmsel_core cmsel_core_props i_props (.clk, .nrst,
    .clock_mode_strap_pins, .system_config_register, .mode_code,
    .mode_locked, .pll_enable, .pll_free_run, .pll_factor,
    .osc_amp_bypass, .osc_watchdog_disable, .core_src_sel, .core_clk,
    .core_edge_rise, .core_edge_fall);
`default_nettype wire

// ### cmsel_core_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cmsel_core_bench;
    import cmsel_pkg::*;
    logic          clk, nrst, mode_locked, pll_enable, pll_free_run;
    logic          osc_amp_bypass, osc_watchdog_disable, core_clk;
    logic          core_edge_rise, core_edge_fall;
    logic [2:0]    clock_mode_strap_pins, mode_code;
    logic [15:0]   system_config_register;
    logic [4:0]    pll_factor;
    cmsel_src_type core_src_sel;
    int            n_mismatch, checks;
    logic [4:0]    ft [0:7] = '{5'h10, 5'h00, 5'h0A, 5'h01,
                                5'h05, 5'h08, 5'h03, 5'h04};
    cmsel_core i_dut (.clk, .nrst, .clock_mode_strap_pins,
        .system_config_register, .mode_code, .mode_locked, .pll_enable,
        .pll_free_run, .pll_factor, .osc_amp_bypass, .osc_watchdog_disable,
        .core_src_sel, .core_clk, .core_edge_rise, .core_edge_fall);
    // Free running input clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task check(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Sample just after the edge so its updates have landed.
    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task do_reset(input logic [2:0] code, input logic dis);
        @(posedge clk);
        nrst <= 1'b0;
        clock_mode_strap_pins <= code;
        system_config_register <= {11'h0, dis, 4'h0};
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        settle(8);
    endtask
    task t_codes;
        for (int c = 0; c < 8; c++) begin
            do_reset(3'(c), 1'b0);
            check("mode", mode_code, 8'(c));
            check("factor", pll_factor, ft[c]);
            check("bypass", osc_amp_bypass, c == 3);
            check("src", core_src_sel, c == 3 ? 1 : c == 1 ? 2 : 0);
            check("locked", mode_locked, 1'b1);
            check("pll_en", pll_enable, 1'b1);
            check("free", pll_free_run, c == 1 || c == 3);
            check("rise", core_edge_rise, c == 3);
        end
    endtask
    task t_presc;
        logic p;
        do_reset(CODE_PRESCL, 1'b0);
        for (int i = 0; i < 6; i++) begin
            p = core_clk;
            settle(1);
            check("cclk", core_clk, !p);
            check("rise", core_edge_rise, !p);
            check("fall", core_edge_fall, p);
        end
    endtask
    task t_wdog;
        do_reset(CODE_DIRECT, 1'b0);
        check("free", pll_free_run, 1'b1);
        check("wdd", osc_watchdog_disable, 1'b0);
        @(posedge clk);
        system_config_register <= 16'h0010;
        settle(1);
        check("wdd", osc_watchdog_disable, 1'b1);
        settle(1);
        check("pll_en", pll_enable, 1'b0);
        check("free", pll_free_run, 1'b0);
        do_reset(CODE_PRESCL, 1'b1);
        check("pll_en", pll_enable, 1'b0);
    endtask
    task t_hold;
        do_reset(CODE_X8, 1'b0);
        @(posedge clk);
        clock_mode_strap_pins <= CODE_X16;
        settle(8);
        check("mode", mode_code, CODE_X8);
        check("factor", pll_factor, FACTOR_8);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence; inputs valued at time zero.
    initial begin
        nrst = 1'b0;
        clock_mode_strap_pins = 3'h7;
        system_config_register = 16'h0000;
        t_codes;
        t_presc;
        t_wdog;
        t_hold;
        final_report;
    end
    // The run needs about 160 cycles; this cuts a hang short.
    initial begin
        #20000;
        n_mismatch++;
        final_report;
    end
endmodule
`default_nettype wire
